// ### extended_arith_unit.sv
/*
 * Extended arithmetic datapath working on the A and B accumulators.
 * Assumes one operation at a time from the host and a one-cycle acknowledge per memory request.
 */
`timescale 1ns/1ns
module extended_arith_unit (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic start_i,
    input wire logic [3:0] op_i,
    input wire logic [4:0] count_i,
    input wire logic [14:0] addr_word_i,
    input wire logic [15:0] a_i,
    input wire logic [15:0] b_i,
    input wire logic [15:0] mem_rdata_i,
    input wire logic mem_ack_i,
    output logic [15:0] a_o,
    output logic [15:0] b_o,
    output logic overflow_o,
    output logic overflow_we_o,
    output logic done_o,
    output logic busy_o,
    output logic mem_req_o,
    output logic mem_we_o,
    output logic [14:0] mem_addr_o,
    output logic [15:0] mem_wdata_o
);
    // ************************************************************
    // State record
    // ************************************************************
    // Everything the unit remembers lives in this one record.
    typedef struct packed {
        ext_arith_pkg::state_t state;
        logic [3:0] op;
        logic [15:0] a;
        logic [15:0] b;
        logic [15:0] operand;
        logic [14:0] m;
        logic [4:0] count;
        logic ovf;
        logic ovf_we;
        logic done;
        logic busy;
        logic mem_req;
        logic mem_we;
        logic [14:0] mem_addr;
        logic [15:0] mem_wdata;
    } regs_t;
    // Registered state and its next value.
    regs_t r_reg;
    regs_t r_next;
    // Signed product of A and the operand, quotient and remainder of B:A, and a divisor kept non-zero.
    logic signed [31:0] product;
    logic signed [31:0] quotient;
    logic signed [31:0] remainder;
    logic signed [31:0] divisor;
    // Divisor is zero or quotient does not fit in one signed word.
    logic div_bad;
    // Pair after one shift step.
    logic [31:0] stepped;
    // ************************************************************
    // Arithmetic and sequencer
    // ************************************************************
    // Both operands are two's complement; the product always fits 32 bits.
    always_comb begin
        product = $signed(r_reg.a) * $signed(r_reg.operand);
        divisor = (r_reg.operand == 16'h0000) ? 32'sh1 : 32'(signed'(r_reg.operand));
        quotient = $signed({r_reg.b, r_reg.a}) / divisor;
        remainder = $signed({r_reg.b, r_reg.a}) % divisor;
        div_bad = (r_reg.operand == 16'h0000) || (quotient > 32'sh7fff) || (quotient < -32'sh8000);
    end
    // One step per clock keeps the shifter small at the cost of n cycles.
    shift_step u_shift_step (
        .pair_i({r_reg.b, r_reg.a}),
        .op_i(r_reg.op),
        .pair_o(stepped)
    );
    // Next-state logic for the whole record.
    always_comb begin
        r_next = r_reg;
        r_next.done = 1'b0;
        r_next.ovf_we = 1'b0;
        case (r_reg.state)
            ext_arith_pkg::ST_IDLE: begin
                // A start while idle latches the operation and the accumulators.
                if (start_i) begin
                    r_next.op = op_i;
                    r_next.a = a_i;
                    r_next.b = b_i;
                    r_next.busy = 1'b1;
                    r_next.count = (count_i == 5'h00 || count_i > ext_arith_pkg::SHIFT_MAX) ?
                        ext_arith_pkg::SHIFT_MAX : count_i;
                    if (op_i <= ext_arith_pkg::OP_DOUBLE_STORE) begin
                        r_next.state = ext_arith_pkg::ST_FETCH_ADDR;
                        r_next.mem_req = 1'b1;
                        r_next.mem_we = 1'b0;
                        r_next.mem_addr = addr_word_i;
                    end else if (op_i == ext_arith_pkg::OP_EXCHANGE) begin
                        r_next.a = b_i;
                        r_next.b = a_i;
                        r_next.busy = 1'b0;
                        r_next.done = 1'b1;
                    end else if (op_i <= ext_arith_pkg::OP_LOGIC_LEFT) begin
                        r_next.state = ext_arith_pkg::ST_SHIFT;
                        r_next.ovf = (op_i == ext_arith_pkg::OP_ARITH_LEFT) ? 1'b0 : r_reg.ovf;
                    end else begin
                        // Unknown codes complete at once, leaving A and B loaded from a_i and b_i.
                        r_next.busy = 1'b0;
                        r_next.done = 1'b1;
                    end
                end
            end
            ext_arith_pkg::ST_FETCH_ADDR: begin
                // The fetched word holds the operand address m.
                if (mem_ack_i) begin
                    r_next.m = mem_rdata_i[14:0];
                    r_next.mem_addr = mem_rdata_i[14:0];
                    if (r_reg.op == ext_arith_pkg::OP_DOUBLE_STORE) begin
                        r_next.state = ext_arith_pkg::ST_WRITE_LO;
                        r_next.mem_we = 1'b1;
                        r_next.mem_wdata = r_reg.a;
                    end else begin
                        r_next.state = ext_arith_pkg::ST_READ_LO;
                    end
                end
            end
            ext_arith_pkg::ST_READ_LO: begin
                if (mem_ack_i) begin
                    if (r_reg.op == ext_arith_pkg::OP_DOUBLE_LOAD) begin
                        r_next.a = mem_rdata_i;
                        r_next.state = ext_arith_pkg::ST_READ_HI;
                        r_next.mem_addr = r_reg.m + ext_arith_pkg::ADDR_STEP;
                    end else begin
                        r_next.operand = mem_rdata_i;
                        r_next.mem_req = 1'b0;
                        r_next.state = ext_arith_pkg::ST_EXEC;
                    end
                end
            end
            ext_arith_pkg::ST_READ_HI: begin
                if (mem_ack_i) begin
                    r_next.b = mem_rdata_i;
                    r_next.mem_req = 1'b0;
                    r_next.state = ext_arith_pkg::ST_IDLE;
                    r_next.busy = 1'b0;
                    r_next.done = 1'b1;
                end
            end
            ext_arith_pkg::ST_WRITE_LO: begin
                if (mem_ack_i) begin
                    r_next.state = ext_arith_pkg::ST_WRITE_HI;
                    r_next.mem_addr = r_reg.m + ext_arith_pkg::ADDR_STEP;
                    r_next.mem_wdata = r_reg.b;
                end
            end
            ext_arith_pkg::ST_WRITE_HI: begin
                if (mem_ack_i) begin
                    r_next.mem_req = 1'b0;
                    r_next.mem_we = 1'b0;
                    r_next.state = ext_arith_pkg::ST_IDLE;
                    r_next.busy = 1'b0;
                    r_next.done = 1'b1;
                end
            end
            ext_arith_pkg::ST_EXEC: begin
                if (r_reg.op == ext_arith_pkg::OP_MULTIPLY) begin
                    r_next.b = product[31:16];
                    r_next.a = product[15:0];
                end else if (div_bad) begin
                    // A failed divide leaves the pair and reports overflow.
                    r_next.ovf = 1'b1;
                    r_next.ovf_we = 1'b1;
                end else begin
                    r_next.a = quotient[15:0];
                    r_next.b = remainder[15:0];
                    r_next.ovf = 1'b0;
                    r_next.ovf_we = 1'b1;
                end
                r_next.state = ext_arith_pkg::ST_IDLE;
                r_next.busy = 1'b0;
                r_next.done = 1'b1;
            end
            ext_arith_pkg::ST_SHIFT: begin
                r_next.b = stepped[31:16];
                r_next.a = stepped[15:0];
                if (r_reg.op == ext_arith_pkg::OP_ARITH_LEFT && (r_reg.b[15] != r_reg.b[14])) begin
                    r_next.ovf = 1'b1;
                end
                r_next.count = r_reg.count - 5'h01;
                if (r_reg.count == ext_arith_pkg::SHIFT_LAST) begin
                    r_next.state = ext_arith_pkg::ST_IDLE;
                    r_next.busy = 1'b0;
                    r_next.done = 1'b1;
                    r_next.ovf_we = (r_reg.op == ext_arith_pkg::OP_ARITH_LEFT);
                end
            end
            default: r_next = '0;
        endcase
    end
    // Synchronous reset clears the whole record.
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end
    // ************************************************************
    // Outputs
    // ************************************************************
    // Every output is a field of the registered record.
    assign a_o = r_reg.a;
    assign b_o = r_reg.b;
    assign overflow_o = r_reg.ovf;
    assign overflow_we_o = r_reg.ovf_we;
    assign done_o = r_reg.done;
    assign busy_o = r_reg.busy;
    assign mem_req_o = r_reg.mem_req;
    assign mem_we_o = r_reg.mem_we;
    assign mem_addr_o = r_reg.mem_addr;
    assign mem_wdata_o = r_reg.mem_wdata;
    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    swap_result_a: assert property (
        r_reg.state == ext_arith_pkg::ST_IDLE && start_i && op_i == ext_arith_pkg::OP_EXCHANGE
        |=> a_o == $past(b_i) && b_o == $past(a_i) && done_o)
        else $error("exchange result wrong");
    addr_first_a: assert property (
        r_reg.state == ext_arith_pkg::ST_IDLE && start_i && op_i <= ext_arith_pkg::OP_DOUBLE_STORE
        |=> mem_req_o && !mem_we_o && mem_addr_o == $past(addr_word_i))
        else $error("address word not fetched first");
    load_high_a: assert property (
        r_reg.state == ext_arith_pkg::ST_READ_LO && mem_ack_i && r_reg.op == ext_arith_pkg::OP_DOUBLE_LOAD
        |=> a_o == $past(mem_rdata_i) && mem_addr_o == $past(r_reg.m) + 15'h0001)
        else $error("double load sequence wrong");
    store_high_a: assert property (
        r_reg.state == ext_arith_pkg::ST_WRITE_LO && mem_ack_i
        |=> mem_we_o && mem_wdata_o == b_o && mem_addr_o == $past(mem_addr_o) + 15'h0001)
        else $error("double store second word wrong");
    mult_result_a: assert property (
        r_reg.state == ext_arith_pkg::ST_EXEC && r_reg.op == ext_arith_pkg::OP_MULTIPLY
        |=> $signed({b_o, a_o}) == $signed($past(r_reg.a)) * $signed($past(r_reg.operand)))
        else $error("multiply result wrong");
    shift_sign_a: assert property (
        r_reg.state == ext_arith_pkg::ST_SHIFT && r_reg.op == ext_arith_pkg::OP_ARITH_LEFT
        |=> b_o[15] == $past(b_o[15]) && a_o[0] == 1'b0)
        else $error("arith left shift changed sign");
    right_fill_a: assert property (
        r_reg.state == ext_arith_pkg::ST_SHIFT && r_reg.op == ext_arith_pkg::OP_LOGIC_RIGHT
        |=> b_o[15] == 1'b0 && b_o[14:0] == $past(b_o[15:1]))
        else $error("logical right shift fill wrong");
    single_step_a: assert property (
        r_reg.state == ext_arith_pkg::ST_IDLE && start_i && op_i == ext_arith_pkg::OP_ROTATE_LEFT
        && count_i == 5'h01 |=> busy_o ##1 done_o && !busy_o)
        else $error("single step shift timing wrong");
    overflow_flag_a: assert property (
        r_reg.state == ext_arith_pkg::ST_SHIFT && r_reg.op == ext_arith_pkg::OP_ARITH_LEFT
        && b_o[15] != b_o[14] |=> overflow_o)
        else $error("overflow not set on sign change");
    done_busy_a: assert property (done_o |-> !busy_o && !mem_req_o)
        else $error("completion while still busy");
    cover_mult_c: cover property (done_o && r_reg.op == ext_arith_pkg::OP_MULTIPLY);
    cover_div_c: cover property (overflow_we_o && r_reg.op == ext_arith_pkg::OP_QUOTIENT);
    cover_asl_ovf_c: cover property (overflow_we_o && overflow_o && r_reg.op == ext_arith_pkg::OP_ARITH_LEFT);
    cover_store_c: cover property (done_o && r_reg.op == ext_arith_pkg::OP_DOUBLE_STORE);
endmodule : extended_arith_unit

// ### ext_arith_pkg.sv
/*
 * Shared constants and types for the extended arithmetic unit.
 * Assumes a 16-bit host with a 15-bit word address space.
 */
package ext_arith_pkg;

    // ************************************************************
    // Widths and limits
    // ************************************************************

    // Accumulator word width.
    localparam int WORD_W = 16;
    // Memory word address width.
    localparam int ADDR_W = 15;
    // Width of the shift count field.
    localparam int COUNT_W = 5;
    // Largest shift count; a zero or larger count is taken as this.
    localparam logic [4:0] SHIFT_MAX = 5'h10;
    // Shift count at which the last step is made.
    localparam logic [4:0] SHIFT_LAST = 5'h01;
    // Address step from the low word to the high word of a pair.
    localparam logic [14:0] ADDR_STEP = 15'h0001;
    // Sign bit and next bit of B inside the 32-bit pair.
    localparam int SIGN_POS = 31;
    localparam int NEXT_POS = 30;

    // ************************************************************
    // Operation codes presented by the host sequencer
    // ************************************************************

    typedef enum logic [3:0] {
        OP_MULTIPLY = 4'h0,
        OP_QUOTIENT = 4'h1,
        OP_DOUBLE_LOAD = 4'h2,
        OP_DOUBLE_STORE = 4'h3,
        OP_ARITH_RIGHT = 4'h4,
        OP_ARITH_LEFT = 4'h5,
        OP_ROTATE_RIGHT = 4'h6,
        OP_ROTATE_LEFT = 4'h7,
        OP_LOGIC_RIGHT = 4'h8,
        OP_LOGIC_LEFT = 4'h9,
        OP_EXCHANGE = 4'ha
    } op_t;

    // ************************************************************
    // Sequencer states, Gray coded along the usual path
    // ************************************************************

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_FETCH_ADDR = 3'h1,
        ST_READ_LO = 3'h3,
        ST_READ_HI = 3'h2,
        ST_WRITE_LO = 3'h6,
        ST_WRITE_HI = 3'h7,
        ST_EXEC = 3'h5,
        ST_SHIFT = 3'h4
    } state_t;

endpackage : ext_arith_pkg

// ### shift_step.sv
/*
 * One-bit shift or rotate step of the 32-bit B:A pair.
 * Assumes the caller repeats it once per clock for n steps.
 */
`timescale 1ns/1ns
module shift_step (
    input wire logic [31:0] pair_i,
    input wire logic [3:0] op_i,
    output logic [31:0] pair_o
);

    // ************************************************************
    // Step selection
    // ************************************************************

    // Bit 31 is B bit 15 and bit 0 is A bit 0 of one value.
    always_comb begin
        case (op_i)
            ext_arith_pkg::OP_ARITH_RIGHT: pair_o = {pair_i[31], pair_i[31:1]};
            ext_arith_pkg::OP_ARITH_LEFT: pair_o = {pair_i[31], pair_i[29:0], 1'b0};
            ext_arith_pkg::OP_ROTATE_RIGHT: pair_o = {pair_i[0], pair_i[31:1]};
            ext_arith_pkg::OP_ROTATE_LEFT: pair_o = {pair_i[30:0], pair_i[31]};
            ext_arith_pkg::OP_LOGIC_RIGHT: pair_o = {1'b0, pair_i[31:1]};
            ext_arith_pkg::OP_LOGIC_LEFT: pair_o = {pair_i[30:0], 1'b0};
            // Other codes never reach the shift state; pass through.
            default: pair_o = pair_i;
        endcase
    end

endmodule : shift_step

// ### mem_model.sv
/*
 * Behavioural core memory that answers the arithmetic unit's memory port.
 * Assumes the unit holds each request until it has taken the acknowledge.
 */
`timescale 1ns/1ns
module mem_model (
    input wire logic clk_i,
    input wire logic req_i,
    input wire logic we_i,
    input wire logic [14:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic [1:0] delay_i,
    output logic ack_o,
    output logic [15:0] rdata_o
);
    // Full word store; the bench fills only the words it uses, the rest read as unknown.
    logic [15:0] mem [0:32767];
    // Wait cycles already spent on the current request.
    logic [1:0] wait_cnt;

    initial begin
        ack_o = 1'b0;
        rdata_o = 16'h0000;
        wait_cnt = 2'h0;
    end

    // The edge after an acknowledge is skipped, since the unit still shows the old request there.
    // words served in order
    always @(posedge clk_i) begin
        if (ack_o || !req_i) begin
            ack_o <= 1'b0;
            wait_cnt <= 2'h0;
            // A released bus must not keep showing the last word.
            rdata_o <= ~rdata_o;
        end else if (wait_cnt != delay_i) begin
            wait_cnt <= wait_cnt + 2'h1;
            rdata_o <= ~rdata_o;
        end else begin
            ack_o <= 1'b1;
            if (we_i) begin
                mem[addr_i] <= wdata_i;
            end else begin
                rdata_o <= mem[addr_i];
            end
        end
    end
endmodule : mem_model

// ### test_extended_arith_unit.sv
/*
 * Self-checking bench for the extended arithmetic unit with a memory model.
 * Assumes the unit's hand-over timing: start taken when idle, done pulse.
 */
`timescale 1ns/1ns
`define CHECK(got, exp) begin checks++; if ((got) !== (exp)) begin failures++; \
    $display("ERROR %0t mismatch got %h exp %h", $time, got, exp); end end
module test_extended_arith_unit;
    logic clk_i = 1'b0;
    logic reset_n = 1'b0;
    logic start = 1'b0;
    logic [3:0] op_r = 4'h0;
    logic [4:0] count_r = 5'h00;
    logic [14:0] addr_word = 15'h0100;
    logic [15:0] a_r = 16'h0000;
    logic [15:0] b_r = 16'h0000;
    logic [1:0] mem_delay = 2'h0;
    logic [15:0] a_o, b_o, mem_rdata, mem_wdata;
    logic [14:0] mem_addr;
    logic overflow_o, overflow_we_o, done_o, busy_o, mem_req, mem_we, mem_ack;
    int failures = 0;
    int checks = 0;
    // Cycles from the start edge to the done pulse.
    int lat;
    logic [31:0] pats [2] = '{32'h9234_5671, 32'h2000_0003};
    logic [4:0] cnts [5] = '{5'h01, 5'h05, 5'h10, 5'h00, 5'h13};

    extended_arith_unit u_extended_arith_unit (.clk_i(clk_i), .reset_n_i(reset_n), .start_i(start),
        .op_i(op_r), .count_i(count_r), .addr_word_i(addr_word), .a_i(a_r), .b_i(b_r),
        .mem_rdata_i(mem_rdata), .mem_ack_i(mem_ack), .a_o(a_o), .b_o(b_o), .overflow_o(overflow_o),
        .overflow_we_o(overflow_we_o), .done_o(done_o), .busy_o(busy_o), .mem_req_o(mem_req),
        .mem_we_o(mem_we), .mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata));
    mem_model u_mem_model (.clk_i(clk_i), .req_i(mem_req), .we_i(mem_we), .addr_i(mem_addr),
        .wdata_i(mem_wdata), .delay_i(mem_delay), .ack_o(mem_ack), .rdata_o(mem_rdata));

    // 50 MHz clock.
    initial begin
        forever #10 clk_i = ~clk_i;
    end

    task automatic wrap_up();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up

    // Starts one operation at a falling edge and waits, bounded, for its done pulse.
    task automatic run_op(input logic [3:0] op, input logic [4:0] n, input logic [15:0] a, input logic [15:0] b);
        int k;
        start = 1'b1;
        op_r = op;
        count_r = n;
        a_r = a;
        b_r = b;
        @(negedge clk_i);
        start = 1'b0;
        lat = 1;
        for (k = 0; k < 200 && done_o !== 1'b1; k++) begin
            @(negedge clk_i);
            lat++;
        end
        if (done_o !== 1'b1) begin
            failures++;
            $display("ERROR %0t no completion", $time);
            wrap_up();
        end
    endtask : run_op

    // Operand address word at 0x0100 points at m = 0x0200.
    task automatic set_operand(input logic [15:0] w0, input logic [15:0] w1, input logic [1:0] dly);
        mem_delay = dly;
        u_mem_model.mem[15'h0100] = 16'h0200;
        u_mem_model.mem[15'h0200] = w0;
        u_mem_model.mem[15'h0201] = w1;
    endtask : set_operand

    // Bench's own step-by-step model of the six shifts; bit 32 is the overflow.
    function automatic logic [32:0] exp_shift(input logic [3:0] op, input logic [31:0] p, input int n);
        logic ov;
        ov = 1'b0;
        for (int i = 0; i < n; i++) begin
            case (op)
                ext_arith_pkg::OP_ARITH_RIGHT: p = {p[31], p[31:1]};
                ext_arith_pkg::OP_ARITH_LEFT: begin
                    ov = ov | (p[31] ^ p[30]);
                    p = {p[31], p[29:0], 1'b0};
                end
                ext_arith_pkg::OP_ROTATE_RIGHT: p = {p[0], p[31:1]};
                ext_arith_pkg::OP_ROTATE_LEFT: p = {p[30:0], p[31]};
                ext_arith_pkg::OP_LOGIC_RIGHT: p = {1'b0, p[31:1]};
                default: p = {p[30:0], 1'b0};
            endcase
        end
        return {ov, p};
    endfunction : exp_shift

    task automatic t_multiply(input logic [15:0] a, input logic [15:0] opnd, input logic [1:0] dly);
        logic [31:0] p;
        p = $signed(a) * $signed(opnd);
        set_operand(opnd, 16'hdead, dly);
        run_op(ext_arith_pkg::OP_MULTIPLY, 5'h00, a, 16'h5555);
        `CHECK({b_o, a_o}, p)
        `CHECK(overflow_we_o, 1'b0)
    endtask : t_multiply

    // quotient and remainder; a refused divide leaves B:A and raises overflow.
    task automatic t_quotient(input logic [31:0] d, input logic [15:0] dvs, input logic [31:0] rq, input logic ov);
        set_operand(dvs, 16'h0000, 2'h1);
        run_op(ext_arith_pkg::OP_QUOTIENT, 5'h00, d[15:0], d[31:16]);
        `CHECK({b_o, a_o}, rq)
        `CHECK({overflow_we_o, overflow_o}, {1'b1, ov})
    endtask : t_quotient

    task automatic t_double();
        set_operand(16'h1111, 16'h2222, 2'h3);
        run_op(ext_arith_pkg::OP_DOUBLE_LOAD, 5'h00, 16'h0000, 16'h0000);
        `CHECK({b_o, a_o}, 32'h2222_1111)
        set_operand(16'h0000, 16'h0000, 2'h0);
        run_op(ext_arith_pkg::OP_DOUBLE_STORE, 5'h00, 16'h5a5a, 16'hc3c3);
        `CHECK(u_mem_model.mem[15'h0200], 16'h5a5a)
        `CHECK(u_mem_model.mem[15'h0201], 16'hc3c3)
    endtask : t_double

    // shift count range; a zero count is taken as sixteen.
    task automatic t_shift(input logic [3:0] op, input logic [4:0] n, input logic [31:0] p);
        int eff;
        logic [32:0] e;
        eff = (n == 5'h00 || n > 5'h10) ? 16 : int'(n);
        e = exp_shift(op, p, eff);
        run_op(op, n, p[15:0], p[31:16]);
        `CHECK({b_o, a_o}, e[31:0])
        `CHECK(lat, eff + 1)
        `CHECK(overflow_we_o, op == ext_arith_pkg::OP_ARITH_LEFT)
        if (op == ext_arith_pkg::OP_ARITH_LEFT) `CHECK(overflow_o, e[32])
    endtask : t_shift

    // a start while busy is ignored
    task automatic t_refuse();
        fork
            run_op(ext_arith_pkg::OP_LOGIC_LEFT, 5'h04, 16'h0001, 16'h0000);
            begin
                repeat (2) @(negedge clk_i);
                `CHECK(busy_o, 1'b1)
                start = 1'b1;
                op_r = ext_arith_pkg::OP_EXCHANGE;
                @(negedge clk_i);
                start = 1'b0;
            end
        join
        `CHECK({b_o, a_o, lat}, {32'h0000_0010, 32'd5})
    endtask : t_refuse

    // exchange in one step; an unknown code completes at once with A and B taken from its inputs.
    task automatic t_single();
        run_op(ext_arith_pkg::OP_EXCHANGE, 5'h00, 16'h1234, 16'habcd);
        `CHECK({b_o, a_o, lat}, {32'h1234_abcd, 32'd1})
        run_op(4'hf, 5'h00, 16'h0f0f, 16'hf0f0);
        `CHECK({b_o, a_o, lat}, {32'hf0f0_0f0f, 32'd1})
        `CHECK(overflow_we_o, 1'b0)
    endtask : t_single

    // Operations are issued back to back, each in the done cycle of the one before.
    initial begin
        repeat (10) @(negedge clk_i);
        `CHECK({done_o, busy_o, mem_req}, 3'h0)
        reset_n = 1'b1;
        t_single();
        t_multiply(16'hfffd, 16'h0007, 2'h0);
        t_multiply(16'h7fff, 16'h8000, 2'h2);
        t_quotient(32'h0000_0064, 16'h0007, 32'h0002_000e, 1'b0);
        t_quotient(32'hffff_ff9c, 16'h0007, 32'hfffe_fff2, 1'b0);
        t_quotient(32'h0001_0000, 16'h0000, 32'h0001_0000, 1'b1);
        t_quotient(32'h7fff_ffff, 16'h0001, 32'h7fff_ffff, 1'b1);
        t_double();
        for (int o = 4; o <= 9; o++) begin
            foreach (pats[i]) begin
                foreach (cnts[j]) begin
                    t_shift(4'(o), cnts[j], pats[i]);
                end
            end
        end
        t_refuse();
        wrap_up();
    end
endmodule : test_extended_arith_unit
